// >>> inc/tccr_map.svh
// tccr_map.svh: register map, field positions, reset values and fixed widths
// of the tuner chip configuration register block.
// assumes inclusion by bare name from the package; the design module uses the macros without including it.
`ifndef TCCR_MAP_SVH
`define TCCR_MAP_SVH

// register index as printed, byte address is four times the index
`define TCCR_CFG_INDEX 6'h06
`define TCCR_APB_ADDR_W 8
`define TCCR_DATA_W 32

// implemented configuration bits 14:0, bits 31:15 reserved
`define TCCR_CFG_BITS 15
`define TCCR_CFG_RESET 15'h0000

// field positions
`define TCCR_BIT_LEVEL_SENSE 0
`define TCCR_BIT_AGC_DISABLE 1
`define TCCR_BIT_AGC_SENSE 2
`define TCCR_BIT_CARRIER_W_LSB 3
`define TCCR_BIT_RESAMP_W_LSB 5
`define TCCR_BIT_CARRIER_OFF_EN 7
`define TCCR_BIT_RESAMP_OFF_EN 8
`define TCCR_BIT_CARRIER_ACC 9
`define TCCR_BIT_RESAMP_ACC 10
`define TCCR_BIT_PHASE_SEL_LSB 11
`define TCCR_BIT_PHASE_CTL 13
`define TCCR_BIT_CLEAR 14

// offset word masks, word is loaded most significant byte first
`define TCCR_MASK_8 32'hFF00_0000
`define TCCR_MASK_16 32'hFFFF_0000
`define TCCR_MASK_24 32'hFFFF_FF00
`define TCCR_MASK_32 32'hFFFF_FFFF

// datapath widths and constants
`define TCCR_LEVEL_W 10
`define TCCR_AGC_W 16
`define TCCR_GAIN_W 16
`define TCCR_GAIN_UNITY 16'h1000
`define TCCR_PHASE_LSB 24
`define TCCR_PHASE_W 5

`endif

// >>> inc/tccr_pkg.sv
// tccr_pkg.sv: types of the tuner chip configuration register block.
// assumes tccr_map.svh is on the include path.
`include "tccr_map.svh"

package tccr_pkg;

	typedef struct packed {
		logic clear_acc;
		logic phase_ctl;
		logic [1:0] phase_sel;
		logic resamp_acc;
		logic carrier_acc;
		logic resamp_off_en;
		logic carrier_off_en;
		logic [1:0] resamp_width;
		logic [1:0] carrier_width;
		logic agc_sense;
		logic agc_disable;
		logic level_sense;
	} tccr_cfg_type;

	typedef struct packed {
		logic carrier_nco;
		logic cic;
		logic agc_loop;
		logic ser_shift_cnt;
		logic ser_clk;
		logic resamp_div;
	} tccr_clear_type;

	typedef struct packed {
		tccr_cfg_type cfg;
		logic pready;
		logic pslverr;
		logic [`TCCR_DATA_W-1:0] prdata;
		logic level_cmp;
		logic [`TCCR_GAIN_W-1:0] agc_gain;
		logic agc_err_neg;
		logic [1:0] carrier_width;
		logic [1:0] resamp_width;
		logic [`TCCR_DATA_W-1:0] carrier_off;
		logic [`TCCR_DATA_W-1:0] resamp_off;
		logic carrier_acc_en;
		logic resamp_acc_en;
		logic [`TCCR_PHASE_W-1:0] sample_phase;
		logic sample_strobe;
		tccr_clear_type clear;
	} tccr_state_type;

endpackage

// >>> verilog/tccr_chip_config.sv
// tccr_chip_config.sv: chip configuration register of the tuner, an APB slave,
// and the sample-clock logic that it steers directly.
// assumes all datapath inputs come from logic on CLK_IN; APB runs on CLK_IN.
//
// Operation
// - bit0 set: level compare high above threshold; clear: high at or below.
// - bit1 set disables the gain loop and forces unity gain.
// - bit2 picks gain error polarity; set gives +1 above threshold, else -1.
// - bits4-3 pick carrier offset word width: 8, 16, 24 or 32 bits.
// - bits6-5 pick resampler offset word width: 8, 16, 24 or 32 bits.
// - bit7 applies the carrier offset; clear gives zero offset.
// - bit8 applies the resampler offset; clear gives zero offset.
// - bit9 enables carrier accumulator feedback; clear zeroes the feedback.
// - bit10 enables resampler accumulator feedback; clear zeroes the feedback.
// - bits12-11 pick phase slice 28:24, 29:25, 30:26 or 31:27.
// - bit13 set: phase and strobe update always; clear: only on valid strobe.
// - writing 1 to bit14 holds accumulators at zero until 0 is written.
// - the clear reaches six items: oscillator, filter, loop, serial and divider.
`timescale 1ns/10ps

module tccr_chip_config
	import tccr_pkg::*;
(
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// apb slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [`TCCR_APB_ADDR_W-1:0] PADDR_IN,
	input wire logic [`TCCR_DATA_W-1:0] PWDATA_IN,
	output logic [`TCCR_DATA_W-1:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// input level detector
	input wire logic [`TCCR_LEVEL_W-1:0] LEVEL_SAMPLE_IN,
	input wire logic [`TCCR_LEVEL_W-1:0] LEVEL_THRESH_IN,
	output logic LEVEL_COMPARE_OUT,
	// gain loop
	input wire logic [`TCCR_AGC_W-1:0] AGC_MAG_IN,
	input wire logic [`TCCR_AGC_W-1:0] AGC_THRESH_IN,
	input wire logic [`TCCR_GAIN_W-1:0] AGC_GAIN_IN,
	output logic [`TCCR_GAIN_W-1:0] AGC_GAIN_OUT,
	output logic AGC_ERROR_NEG_OUT,
	// oscillator offsets and accumulators
	input wire logic [`TCCR_DATA_W-1:0] CARRIER_OFFSET_IN,
	input wire logic [`TCCR_DATA_W-1:0] RESAMP_OFFSET_IN,
	output logic [1:0] CARRIER_WIDTH_OUT,
	output logic [1:0] RESAMP_WIDTH_OUT,
	output logic [`TCCR_DATA_W-1:0] CARRIER_OFFSET_OUT,
	output logic [`TCCR_DATA_W-1:0] RESAMP_OFFSET_OUT,
	output logic CARRIER_ACC_EN_OUT,
	output logic RESAMP_ACC_EN_OUT,
	// sample phase
	input wire logic [`TCCR_DATA_W-1:0] RESAMP_PHASE_IN,
	input wire logic RESAMP_STROBE_IN,
	input wire logic OUTPUT_VALID_STROBE_IN,
	output logic [`TCCR_PHASE_W-1:0] SAMPLE_PHASE_OUT,
	output logic SAMPLE_STROBE_OUT,
	// accumulator clears
	output tccr_clear_type CLEAR_OUT
);

	tccr_state_type st_q;
	tccr_state_type st_d;
	logic setup;
	logic hit;
	logic wr_acc;
	logic level_above;
	logic agc_above;

	assign setup = PSEL_IN & ~PENABLE_IN;
	assign hit = (PADDR_IN[`TCCR_APB_ADDR_W-1:2] == `TCCR_CFG_INDEX) && (PADDR_IN[1:0] == 2'h0);
	assign wr_acc = PSEL_IN & PENABLE_IN & st_q.pready & PWRITE_IN & hit;
	assign level_above = LEVEL_SAMPLE_IN > LEVEL_THRESH_IN;
	assign agc_above = AGC_MAG_IN > AGC_THRESH_IN;

	function automatic logic [`TCCR_DATA_W-1:0] width_mask(input logic [1:0] code);
		logic [`TCCR_DATA_W-1:0] m;
		unique case (code)
			2'h0: m = `TCCR_MASK_8;
			2'h1: m = `TCCR_MASK_16;
			2'h2: m = `TCCR_MASK_24;
			2'h3: m = `TCCR_MASK_32;
		endcase
		return m;
	endfunction

	always_comb begin
		st_d = st_q;
		// zero-wait slave: ready is raised for the access phase that follows setup
		st_d.pready = setup;
		st_d.pslverr = setup & ~hit;
		if (setup) begin
			st_d.prdata = (hit & ~PWRITE_IN) ? 32'(st_q.cfg) : 32'h0000_0000;
		end
		if (wr_acc) begin
			st_d.cfg = tccr_cfg_type'(PWDATA_IN[`TCCR_CFG_BITS-1:0]);
		end
		st_d.level_cmp = st_q.cfg.level_sense ? level_above : ~level_above;
		st_d.agc_gain = st_q.cfg.agc_disable ? `TCCR_GAIN_UNITY : AGC_GAIN_IN;
		st_d.agc_err_neg = st_q.cfg.agc_sense ? ~agc_above : agc_above;
		st_d.carrier_width = st_q.cfg.carrier_width;
		st_d.resamp_width = st_q.cfg.resamp_width;
		st_d.carrier_off = st_q.cfg.carrier_off_en ?
			(CARRIER_OFFSET_IN & width_mask(st_q.cfg.carrier_width)) : 32'h0000_0000;
		st_d.resamp_off = st_q.cfg.resamp_off_en ?
			(RESAMP_OFFSET_IN & width_mask(st_q.cfg.resamp_width)) : 32'h0000_0000;
		st_d.carrier_acc_en = st_q.cfg.carrier_acc;
		st_d.resamp_acc_en = st_q.cfg.resamp_acc;
		if (st_q.cfg.phase_ctl | OUTPUT_VALID_STROBE_IN) begin
			st_d.sample_phase = RESAMP_PHASE_IN[`TCCR_PHASE_LSB + int'(st_q.cfg.phase_sel) +: `TCCR_PHASE_W];
			st_d.sample_strobe = RESAMP_STROBE_IN;
		end
		st_d.clear = {6{st_q.cfg.clear_acc}};
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			st_q <= '0;
			st_q.cfg <= `TCCR_CFG_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign PRDATA_OUT = st_q.prdata;
	assign PREADY_OUT = st_q.pready;
	assign PSLVERR_OUT = st_q.pslverr;
	assign LEVEL_COMPARE_OUT = st_q.level_cmp;
	assign AGC_GAIN_OUT = st_q.agc_gain;
	assign AGC_ERROR_NEG_OUT = st_q.agc_err_neg;
	assign CARRIER_WIDTH_OUT = st_q.carrier_width;
	assign RESAMP_WIDTH_OUT = st_q.resamp_width;
	assign CARRIER_OFFSET_OUT = st_q.carrier_off;
	assign RESAMP_OFFSET_OUT = st_q.resamp_off;
	assign CARRIER_ACC_EN_OUT = st_q.carrier_acc_en;
	assign RESAMP_ACC_EN_OUT = st_q.resamp_acc_en;
	assign SAMPLE_PHASE_OUT = st_q.sample_phase;
	assign SAMPLE_STROBE_OUT = st_q.sample_strobe;
	assign CLEAR_OUT = st_q.clear;

	// checks

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);

	logic chk_level;
	logic chk_agc_neg;
	logic [`TCCR_PHASE_W-1:0] chk_slice;
	logic chk_cfg_wr_clear;
	logic [`TCCR_CFG_BITS-1:0] chk_cfg_bits;

	assign chk_level = chk_cfg_bits[`TCCR_BIT_LEVEL_SENSE] ? (LEVEL_SAMPLE_IN > LEVEL_THRESH_IN) :
		(LEVEL_SAMPLE_IN <= LEVEL_THRESH_IN);
	assign chk_cfg_bits = st_q.cfg;
	assign chk_cfg_wr_clear = wr_acc & PWDATA_IN[`TCCR_BIT_CLEAR];

	always_comb begin
		chk_agc_neg = 1'b0;
		if (chk_cfg_bits[`TCCR_BIT_AGC_SENSE]) begin
			chk_agc_neg = !(AGC_MAG_IN > AGC_THRESH_IN);
		end else begin
			chk_agc_neg = AGC_MAG_IN > AGC_THRESH_IN;
		end
	end

	always_comb begin
		chk_slice = '0;
		case (chk_cfg_bits[`TCCR_BIT_PHASE_SEL_LSB +: 2])
			2'h0: chk_slice = RESAMP_PHASE_IN[28:24];
			2'h1: chk_slice = RESAMP_PHASE_IN[29:25];
			2'h2: chk_slice = RESAMP_PHASE_IN[30:26];
			default: chk_slice = RESAMP_PHASE_IN[31:27];
		endcase
	end

	property p_level_above;
		chk_cfg_bits[`TCCR_BIT_LEVEL_SENSE] && (LEVEL_SAMPLE_IN > LEVEL_THRESH_IN) |=> LEVEL_COMPARE_OUT;
	endproperty
	a_level_above: assert property (p_level_above) else $error("level compare low above threshold");

	property p_level_at_or_below;
		!chk_cfg_bits[`TCCR_BIT_LEVEL_SENSE] && (LEVEL_SAMPLE_IN <= LEVEL_THRESH_IN) |=> LEVEL_COMPARE_OUT;
	endproperty
	a_level_at_or_below: assert property (p_level_at_or_below) else $error("level compare low at threshold");

	property p_agc_unity;
		chk_cfg_bits[`TCCR_BIT_AGC_DISABLE] |=> AGC_GAIN_OUT == `TCCR_GAIN_UNITY;
	endproperty
	a_agc_unity: assert property (p_agc_unity) else $error("gain not unity while loop disabled");

	property p_agc_pass;
		!chk_cfg_bits[`TCCR_BIT_AGC_DISABLE] |=> AGC_GAIN_OUT == $past(AGC_GAIN_IN);
	endproperty
	a_agc_pass: assert property (p_agc_pass) else $error("gain not passed in normal operation");

	property p_agc_err;
		1'b1 |=> AGC_ERROR_NEG_OUT == $past(chk_agc_neg);
	endproperty
	a_agc_err: assert property (p_agc_err) else $error("gain error polarity wrong");

	property p_carrier_8;
		chk_cfg_bits[`TCCR_BIT_CARRIER_W_LSB +: 2] == 2'h0 |=> CARRIER_OFFSET_OUT[23:0] == 24'h00_0000;
	endproperty
	a_carrier_8: assert property (p_carrier_8) else $error("carrier offset wider than 8 bits");

	property p_resamp_16;
		chk_cfg_bits[`TCCR_BIT_RESAMP_W_LSB +: 2] == 2'h1 |=> RESAMP_OFFSET_OUT[15:0] == 16'h0000;
	endproperty
	a_resamp_16: assert property (p_resamp_16) else $error("resampler offset wider than 16 bits");

	property p_carrier_off;
		!chk_cfg_bits[`TCCR_BIT_CARRIER_OFF_EN] |=> CARRIER_OFFSET_OUT == 32'h0000_0000;
	endproperty
	a_carrier_off: assert property (p_carrier_off) else $error("carrier offset not zero when gated");

	property p_resamp_off;
		!chk_cfg_bits[`TCCR_BIT_RESAMP_OFF_EN] |=> RESAMP_OFFSET_OUT == 32'h0000_0000;
	endproperty
	a_resamp_off: assert property (p_resamp_off) else $error("resampler offset not zero when gated");

	property p_carrier_acc;
		1'b1 |=> CARRIER_ACC_EN_OUT == $past(chk_cfg_bits[`TCCR_BIT_CARRIER_ACC]);
	endproperty
	a_carrier_acc: assert property (p_carrier_acc) else $error("carrier feedback enable wrong");

	property p_resamp_acc;
		1'b1 |=> RESAMP_ACC_EN_OUT == $past(chk_cfg_bits[`TCCR_BIT_RESAMP_ACC]);
	endproperty
	a_resamp_acc: assert property (p_resamp_acc) else $error("resampler feedback enable wrong");

	property p_phase_slice;
		chk_cfg_bits[`TCCR_BIT_PHASE_CTL] |=> SAMPLE_PHASE_OUT == $past(chk_slice);
	endproperty
	a_phase_slice: assert property (p_phase_slice) else $error("sample phase slice wrong");

	property p_phase_hold;
		!chk_cfg_bits[`TCCR_BIT_PHASE_CTL] && !OUTPUT_VALID_STROBE_IN |=> $stable(SAMPLE_PHASE_OUT) && $stable(SAMPLE_STROBE_OUT);
	endproperty
	a_phase_hold: assert property (p_phase_hold) else $error("sample phase moved without valid strobe");

	property p_clear_hold;
		chk_cfg_wr_clear ##1 !wr_acc [*3] |-> ##1 CLEAR_OUT == 6'h3F;
	endproperty
	a_clear_hold: assert property (p_clear_hold) else $error("clear not held after write");

	property p_reserved;
		PREADY_OUT |-> PRDATA_OUT[31:15] == 17'h0_0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

	property p_write_takes;
		wr_acc |=> chk_cfg_bits == $past(PWDATA_IN[`TCCR_CFG_BITS-1:0]) ##1 CARRIER_ACC_EN_OUT == $past(chk_cfg_bits[`TCCR_BIT_CARRIER_ACC]);
	endproperty
	a_write_takes: assert property (p_write_takes) else $error("written field not taken");

	property p_ready_after_setup;
		setup |=> PREADY_OUT ##1 !PREADY_OUT;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready not one access cycle");

	property p_level_cmp;
		1'b1 |=> LEVEL_COMPARE_OUT == $past(chk_level);
	endproperty
	a_level_cmp: assert property (p_level_cmp) else $error("level compare sense wrong");

	property p_carrier_16;
		chk_cfg_bits[`TCCR_BIT_CARRIER_W_LSB +: 2] == 2'h1 |=> CARRIER_OFFSET_OUT[15:0] == 16'h0000;
	endproperty
	a_carrier_16: assert property (p_carrier_16) else $error("carrier offset wider than 16 bits");

	property p_carrier_24;
		chk_cfg_bits[`TCCR_BIT_CARRIER_W_LSB +: 2] == 2'h2 |=> CARRIER_OFFSET_OUT[7:0] == 8'h00;
	endproperty
	a_carrier_24: assert property (p_carrier_24) else $error("carrier offset wider than 24 bits");

	property p_carrier_32;
		chk_cfg_bits[`TCCR_BIT_CARRIER_W_LSB +: 2] == 2'h3 && chk_cfg_bits[`TCCR_BIT_CARRIER_OFF_EN]
			|=> CARRIER_OFFSET_OUT == $past(CARRIER_OFFSET_IN);
	endproperty
	a_carrier_32: assert property (p_carrier_32) else $error("carrier offset not full width");

	property p_resamp_8;
		chk_cfg_bits[`TCCR_BIT_RESAMP_W_LSB +: 2] == 2'h0 |=> RESAMP_OFFSET_OUT[23:0] == 24'h00_0000;
	endproperty
	a_resamp_8: assert property (p_resamp_8) else $error("resampler offset wider than 8 bits");

	property p_resamp_24;
		chk_cfg_bits[`TCCR_BIT_RESAMP_W_LSB +: 2] == 2'h2 |=> RESAMP_OFFSET_OUT[7:0] == 8'h00;
	endproperty
	a_resamp_24: assert property (p_resamp_24) else $error("resampler offset wider than 24 bits");

	property p_resamp_32;
		chk_cfg_bits[`TCCR_BIT_RESAMP_W_LSB +: 2] == 2'h3 && chk_cfg_bits[`TCCR_BIT_RESAMP_OFF_EN]
			|=> RESAMP_OFFSET_OUT == $past(RESAMP_OFFSET_IN);
	endproperty
	a_resamp_32: assert property (p_resamp_32) else $error("resampler offset not full width");

	property p_carrier_on;
		chk_cfg_bits[`TCCR_BIT_CARRIER_OFF_EN] |=> CARRIER_OFFSET_OUT[31:24] == $past(CARRIER_OFFSET_IN[31:24]);
	endproperty
	a_carrier_on: assert property (p_carrier_on) else $error("carrier offset not applied");

	property p_resamp_on;
		chk_cfg_bits[`TCCR_BIT_RESAMP_OFF_EN] |=> RESAMP_OFFSET_OUT[31:24] == $past(RESAMP_OFFSET_IN[31:24]);
	endproperty
	a_resamp_on: assert property (p_resamp_on) else $error("resampler offset not applied");

	property p_strobe_follow;
		chk_cfg_bits[`TCCR_BIT_PHASE_CTL] || OUTPUT_VALID_STROBE_IN |=> SAMPLE_STROBE_OUT == $past(RESAMP_STROBE_IN);
	endproperty
	a_strobe_follow: assert property (p_strobe_follow) else $error("sample strobe not updated");

	property p_clear_on;
		chk_cfg_bits[`TCCR_BIT_CLEAR] |=> CLEAR_OUT == 6'h3F;
	endproperty
	a_clear_on: assert property (p_clear_on) else $error("clear not reaching all six items");

	property p_clear_off;
		!chk_cfg_bits[`TCCR_BIT_CLEAR] |=> CLEAR_OUT == 6'h00;
	endproperty
	a_clear_off: assert property (p_clear_off) else $error("clear active after zero written");

	property p_cov_level_equal;
		!chk_cfg_bits[`TCCR_BIT_LEVEL_SENSE] && LEVEL_SAMPLE_IN == LEVEL_THRESH_IN ##1 LEVEL_COMPARE_OUT;
	endproperty
	c_level_equal: cover property (p_cov_level_equal);

	property p_cov_clear;
		chk_cfg_wr_clear ##2 CLEAR_OUT == 6'h3F;
	endproperty
	c_clear: cover property (p_cov_clear);

	property p_cov_strobe_update;
		!chk_cfg_bits[`TCCR_BIT_PHASE_CTL] && OUTPUT_VALID_STROBE_IN ##1 $changed(SAMPLE_PHASE_OUT);
	endproperty
	c_strobe_update: cover property (p_cov_strobe_update);

	property p_cov_unmapped;
		PREADY_OUT && PSLVERR_OUT;
	endproperty
	c_unmapped: cover property (p_cov_unmapped);

	property p_cov_readback;
		PREADY_OUT && !PSLVERR_OUT && PRDATA_OUT != 32'h0000_0000;
	endproperty
	c_readback: cover property (p_cov_readback);

endmodule

// >>> testbench/tccr_host_model.sv
// tccr_host_model.sv: host processor on the apb side, one transfer per call.
// assumes a single clock shared with the register block.
`timescale 1ns/10ps

module tccr_host_model (
	// clock
	input wire logic clk_in,
	// apb master
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [7:0] paddr_out,
	output logic [31:0] pwdata_out,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in
);
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h0;
	end

	// waits an edge first, so back-to-back calls never drive twice in one step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_in);
		psel_out <= 1'b1;
		penable_out <= 1'b0;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clk_in);
		penable_out <= 1'b1;
		do @(posedge clk_in); while (pready_in !== 1'b1);
		r = prdata_in;
		e = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		paddr_out <= ~a;
		pwdata_out <= ~d;
	endtask
endmodule

// >>> testbench/tb_tuner_chip_config_register.sv
// tb_tuner_chip_config_register.sv: self-checking bench of the configuration register.
// assumes the register sits at byte address 8'h18 and answers with no wait states.
`timescale 1ns/10ps

module tb_tuner_chip_config_register;
	import tccr_pkg::*;

	typedef struct packed {
		logic [14:0] cfg;
		logic [9:0] lvl;
		logic [15:0] mag;
		logic cmp;
		logic [15:0] gain;
		logic err;
		logic [31:0] coff;
		logic [31:0] roff;
		logic [4:0] ph;
	} tccr_row_type;

	localparam tccr_row_type ROWS [7] = '{
		'{15'h0000, 10'h100, 16'h0100, 1'b1, 16'h0ABC, 1'b0, 32'h0, 32'h0, 5'h05},
		'{15'h0187, 10'h200, 16'h0200, 1'b1, 16'h1000, 1'b0, 32'h1200_0000, 32'h1200_0000, 5'h05},
		'{15'h01C8, 10'h200, 16'h0200, 1'b0, 16'h0ABC, 1'b1, 32'h1234_0000, 32'h1234_5600, 5'h05},
		'{15'h2FF8, 10'h0FF, 16'h00FF, 1'b1, 16'h0ABC, 1'b0, 32'h1234_5678, 32'h1234_5678, 5'h12},
		'{15'h5000, 10'h200, 16'h0200, 1'b0, 16'h0ABC, 1'b1, 32'h0, 32'h0, 5'h09},
		'{15'h1800, 10'h200, 16'h0200, 1'b0, 16'h0ABC, 1'b1, 32'h0, 32'h0, 5'h14},
		'{15'h01B5, 10'h100, 16'h0100, 1'b0, 16'h0ABC, 1'b1, 32'h1234_5600, 32'h1234_0000, 5'h05}};

	logic CLK_IN, RST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT;
	logic [7:0] PADDR_IN;
	logic [31:0] PWDATA_IN, PRDATA_OUT, CARRIER_OFFSET_OUT, RESAMP_OFFSET_OUT, RESAMP_PHASE_IN;
	logic LEVEL_COMPARE_OUT, AGC_ERROR_NEG_OUT, CARRIER_ACC_EN_OUT, RESAMP_ACC_EN_OUT;
	logic [15:0] AGC_GAIN_OUT, AGC_MAG_IN;
	logic [9:0] LEVEL_SAMPLE_IN;
	logic [1:0] CARRIER_WIDTH_OUT, RESAMP_WIDTH_OUT;
	logic [4:0] SAMPLE_PHASE_OUT;
	logic SAMPLE_STROBE_OUT, RESAMP_STROBE_IN, OUTPUT_VALID_STROBE_IN;
	tccr_clear_type CLEAR_OUT;
	logic [31:0] rdat;
	logic serr;
	int err_count, check_count;

	tccr_chip_config tccr_chip_config_i (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
		.PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
		.PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
		.LEVEL_SAMPLE_IN(LEVEL_SAMPLE_IN), .LEVEL_THRESH_IN(10'h100), .LEVEL_COMPARE_OUT(LEVEL_COMPARE_OUT),
		.AGC_MAG_IN(AGC_MAG_IN), .AGC_THRESH_IN(16'h0100), .AGC_GAIN_IN(16'h0ABC),
		.AGC_GAIN_OUT(AGC_GAIN_OUT), .AGC_ERROR_NEG_OUT(AGC_ERROR_NEG_OUT),
		.CARRIER_OFFSET_IN(32'h1234_5678), .RESAMP_OFFSET_IN(32'h1234_5678),
		.CARRIER_WIDTH_OUT(CARRIER_WIDTH_OUT), .RESAMP_WIDTH_OUT(RESAMP_WIDTH_OUT),
		.CARRIER_OFFSET_OUT(CARRIER_OFFSET_OUT), .RESAMP_OFFSET_OUT(RESAMP_OFFSET_OUT),
		.CARRIER_ACC_EN_OUT(CARRIER_ACC_EN_OUT), .RESAMP_ACC_EN_OUT(RESAMP_ACC_EN_OUT),
		.RESAMP_PHASE_IN(RESAMP_PHASE_IN), .RESAMP_STROBE_IN(RESAMP_STROBE_IN),
		.OUTPUT_VALID_STROBE_IN(OUTPUT_VALID_STROBE_IN), .SAMPLE_PHASE_OUT(SAMPLE_PHASE_OUT),
		.SAMPLE_STROBE_OUT(SAMPLE_STROBE_OUT), .CLEAR_OUT(CLEAR_OUT));

	tccr_host_model tccr_host_model_i (.clk_in(CLK_IN), .psel_out(PSEL_IN), .penable_out(PENABLE_IN),
		.pwrite_out(PWRITE_IN), .paddr_out(PADDR_IN), .pwdata_out(PWDATA_IN),
		.prdata_in(PRDATA_OUT), .pready_in(PREADY_OUT), .pslverr_in(PSLVERR_OUT));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// write, then let the derived outputs settle one edge after the write edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		tccr_host_model_i.xfer(1'b1, a, d, rdat, serr);
		repeat (2) @(posedge CLK_IN);
		#1;
	endtask

	task automatic rd(input logic [7:0] a);
		tccr_host_model_i.xfer(1'b0, a, 32'h0, rdat, serr);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		CLK_IN = 1'b0;
		forever #5 CLK_IN = ~CLK_IN;
	end

	initial begin
		#100000;
		err_count++;
		wrap_up();
	end

	initial begin
		RST_IN = 1'b1;
		RESAMP_PHASE_IN = 32'hA500_0000;
		LEVEL_SAMPLE_IN = 10'h200;
		AGC_MAG_IN = 16'h0200;
		RESAMP_STROBE_IN = 1'b1;
		OUTPUT_VALID_STROBE_IN = 1'b1;
		repeat (4) @(posedge CLK_IN);
		RST_IN <= 1'b0;
		rd(8'h18);
		chk(rdat, 32'h0);
		for (int i = 0; i < 7; i++) begin
			LEVEL_SAMPLE_IN <= ROWS[i].lvl;
			AGC_MAG_IN <= ROWS[i].mag;
			wr(8'h18, {17'h0, ROWS[i].cfg});
			chk(serr, 1'b0);
			chk(LEVEL_COMPARE_OUT, ROWS[i].cmp);
			chk(AGC_GAIN_OUT, ROWS[i].gain);
			chk(AGC_ERROR_NEG_OUT, ROWS[i].err);
			chk(CARRIER_WIDTH_OUT, ROWS[i].cfg[4:3]);
			chk(RESAMP_WIDTH_OUT, ROWS[i].cfg[6:5]);
			chk(CARRIER_OFFSET_OUT, ROWS[i].coff);
			chk(RESAMP_OFFSET_OUT, ROWS[i].roff);
			chk(CARRIER_ACC_EN_OUT, ROWS[i].cfg[9]);
			chk(RESAMP_ACC_EN_OUT, ROWS[i].cfg[10]);
			chk(SAMPLE_PHASE_OUT, ROWS[i].ph);
			chk(CLEAR_OUT, {6{ROWS[i].cfg[14]}});
			rd(8'h18);
			chk(rdat, {17'h0, ROWS[i].cfg});
		end
		wr(8'h18, 32'h0);
		@(posedge CLK_IN);
		OUTPUT_VALID_STROBE_IN <= 1'b0;
		RESAMP_PHASE_IN <= 32'h1F00_0000;
		RESAMP_STROBE_IN <= 1'b0;
		repeat (3) @(posedge CLK_IN);
		#1;
		chk(SAMPLE_PHASE_OUT, 5'h05);
		chk(SAMPLE_STROBE_OUT, 1'b1);
		wr(8'h18, 32'h2000);
		chk(SAMPLE_PHASE_OUT, 5'h1F);
		chk(SAMPLE_STROBE_OUT, 1'b0);
		wr(8'h18, 32'hFFFF_C000);
		rd(8'h18);
		chk(rdat, 32'h0000_4000);
		wr(8'h18, 32'h0000_4600);
		chk(CLEAR_OUT, 6'h3F);
		wr(8'h1C, 32'h0);
		chk(serr, 1'b1);
		chk(CLEAR_OUT, 6'h3F);
		rd(8'h1C);
		chk(serr, 1'b1);
		chk(rdat, 32'h0);
		wr(8'h18, 32'h0);
		chk(CLEAR_OUT, 6'h00);
		wr(8'h18, 32'h0187);
		@(posedge CLK_IN);
		RST_IN <= 1'b1;
		repeat (4) @(posedge CLK_IN);
		RST_IN <= 1'b0;
		rd(8'h18);
		chk(rdat, 32'h0);
		chk(CARRIER_OFFSET_OUT, 32'h0);
		wrap_up();
	end
endmodule
